// File: logic/smci_pkg.sv
// constants and types shared by the serial client interface
package smci_pkg;

  // ==========================================================
  // timing
  localparam int unsigned SMCI_CORE_HZ = 25_000_000;
  localparam int unsigned SMCI_TMO_MS = 30;
  localparam int unsigned SMCI_TMO_CYCLES = SMCI_CORE_HZ / 1000 * SMCI_TMO_MS;
  localparam int SMCI_TMO_W = 20;
  localparam logic [1:0] SMCI_STRAP_WAIT = 2'h2;

  // ==========================================================
  // byte framing
  localparam logic [3:0] SMCI_LAST_BIT = 4'h7;
  localparam logic [3:0] SMCI_ACK_SLOT = 4'h8;
  localparam logic [7:0] SMCI_PTR_RST = 8'h00;

  // ==========================================================
  // addressing
  localparam logic [3:0] SMCI_STRAP_OPEN = 4'hf;
  localparam logic [3:0] SMCI_GRP_A = 4'h9;
  localparam logic [3:0] SMCI_GRP_B = 4'h5;
  localparam logic [3:0] SMCI_GRP_B_BASE = 4'h8;
  localparam logic [2:0] SMCI_GRP_A_FLIP = 3'h4;
  localparam logic [6:0] SMCI_OPEN_ADDR = 7'h18;
  localparam logic [6:0] SMCI_ARA_ADDR = 7'h0c;
  localparam logic [6:0] SMCI_ADDR_RST = 7'h00;

  // ==========================================================
  // state machines
  typedef enum logic [2:0] {
    LK_ADDR,
    LK_REG,
    LK_WDATA,
    LK_RFIRST,
    LK_RDATA,
    LK_IGNORE
  } smci_link_st_t;

  typedef enum logic {
    CO_IDLE,
    CO_PTR
  } smci_core_st_t;

endpackage

// File: logic/smci_sync.sv
// two-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
`default_nettype none

module smci_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // levels
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // ==========================================================
  // first stage feeds only the second stage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

`default_nettype wire

// File: logic/smci_client.sv
// two-wire client interface: link engine and core-side control
`timescale 1ns/1ps
`default_nettype none

module smci_client
  import smci_pkg::*;
#(
  parameter int unsigned TMO_CYCLES = SMCI_TMO_CYCLES
) (
  // core clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // serial link
  input wire logic i_serial_clock_pin,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // address strap and guard enable
  input wire logic [3:0] i_addr_strap,
  input wire logic i_timeout_en,
  // register port
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  output logic o_reg_wr,
  input wire logic [7:0] i_reg_rdata,
  // status
  output logic [6:0] o_dev_addr
);

  localparam logic [SMCI_TMO_W-1:0] TMO_LIM = SMCI_TMO_W'(TMO_CYCLES);

  function automatic logic [6:0] strap_addr(input logic [3:0] code);
    logic [6:0] a;
    a = SMCI_OPEN_ADDR;
    if (code < SMCI_GRP_B_BASE) begin
      a = {SMCI_GRP_A, code[2:0] ^ SMCI_GRP_A_FLIP};
    end else if (code != SMCI_STRAP_OPEN) begin
      a = {SMCI_GRP_B, code[2:0]};
    end
    return a;
  endfunction

  // ==========================================================
  // core-domain declarations
  logic [1:0] pins_s;
  logic [3:0] strap_s;
  logic evt_s;
  logic scl_s;
  logic sda_s;
  logic scl_q, scl_d;
  logic sda_q, sda_d;
  logic active_q, active_d;
  logic clr_q, clr_d;
  logic [SMCI_TMO_W-1:0] tmo_cnt_q, tmo_cnt_d;
  logic [1:0] strap_cnt_q, strap_cnt_d;
  logic strap_done_q, strap_done_d;
  logic [6:0] dev_addr_q, dev_addr_d;
  logic seen_q, seen_d;
  smci_core_st_t cst_q, cst_d;
  logic [7:0] reg_addr_q, reg_addr_d;
  logic [7:0] reg_wdata_q, reg_wdata_d;
  logic reg_wr_q, reg_wr_d;
  logic [7:0] rd_q, rd_d;
  logic start_w;
  logic stop_w;
  logic tmo_w;

  // ==========================================================
  // link-domain declarations
  logic link_rst;
  smci_link_st_t lst_q, lst_d;
  logic [3:0] bcnt_q, bcnt_d;
  logic [6:0] shf_q, shf_d;
  logic ack_q, ack_d;
  logic ara_q, ara_d;
  logic [7:0] ptr_q, ptr_d;
  logic tgl_q, tgl_d;
  logic ewr_q, ewr_d;
  logic [7:0] eaddr_q, eaddr_d;
  logic [7:0] edata_q, edata_d;
  logic [7:0] tx_q, tx_d;
  logic oe_q, oe_d;
  logic [7:0] byte_w;

  // ==========================================================
  // synchronisers; oversampling at 25 MHz covers the whole link range
  smci_sync #(.WIDTH(2)) u_pin_sync (
    .i_clk(i_core_clk),
    .i_rst(i_sys_rst),
    .i_async({i_serial_clock_pin, i_sda}),
    .o_sync(pins_s)
  );

  smci_sync #(.WIDTH(4)) u_strap_sync (
    .i_clk(i_core_clk),
    .i_rst(i_sys_rst),
    .i_async(i_addr_strap),
    .o_sync(strap_s)
  );

  smci_sync #(.WIDTH(1)) u_evt_sync (
    .i_clk(i_core_clk),
    .i_rst(i_sys_rst),
    .i_async(tgl_q),
    .o_sync(evt_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // ==========================================================
  // core control: frame detection, guard, strap, register port
  always_comb begin
    start_w = scl_s & scl_q & sda_q & ~sda_s;
    stop_w = scl_s & scl_q & ~sda_q & sda_s;
    tmo_w = active_q & i_timeout_en & (tmo_cnt_q == TMO_LIM);
    scl_d = scl_s;
    sda_d = sda_s;
    // counts only a low clock; stretching below the limit is harmless
    tmo_cnt_d = tmo_cnt_q;
    if (scl_s || !i_timeout_en) begin
      tmo_cnt_d = '0;
    end else if (tmo_cnt_q != TMO_LIM) begin
      tmo_cnt_d = tmo_cnt_q + 1'b1;
    end
    // a start or stop holds the link engine in reset for one cycle;
    // the link clock is high then, so release meets no edge
    clr_d = start_w | stop_w | tmo_w;
    active_d = active_q;
    if (stop_w || tmo_w) begin
      active_d = 1'b0;
    end else if (start_w && strap_done_q) begin
      active_d = 1'b1;
    end
    strap_cnt_d = strap_cnt_q;
    strap_done_d = strap_done_q;
    dev_addr_d = dev_addr_q;
    if (!strap_done_q) begin
      strap_cnt_d = strap_cnt_q + 2'h1;
      if (strap_cnt_q == SMCI_STRAP_WAIT) begin
        dev_addr_d = strap_addr(strap_s);
        strap_done_d = 1'b1;
      end
    end
    seen_d = evt_s;
    cst_d = cst_q;
    reg_addr_d = reg_addr_q;
    reg_wdata_d = reg_wdata_q;
    reg_wr_d = 1'b0;
    rd_d = rd_q;
    unique case (cst_q)
      CO_IDLE: begin
        rd_d = i_reg_rdata;
        if (evt_s != seen_q) begin
          if (ewr_q) begin
            reg_addr_d = eaddr_q;
            reg_wdata_d = edata_q;
            reg_wr_d = 1'b1;
            cst_d = CO_PTR;
          end else begin
            reg_addr_d = ptr_q;
          end
        end
      end
      CO_PTR: begin
        reg_addr_d = ptr_q;
        cst_d = CO_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      active_q <= 1'b0;
      clr_q <= 1'b0;
      tmo_cnt_q <= '0;
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
      dev_addr_q <= SMCI_ADDR_RST;
      seen_q <= 1'b0;
      cst_q <= CO_IDLE;
      reg_addr_q <= SMCI_PTR_RST;
      reg_wdata_q <= 8'h00;
      reg_wr_q <= 1'b0;
      rd_q <= 8'h00;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
      active_q <= active_d;
      clr_q <= clr_d;
      tmo_cnt_q <= tmo_cnt_d;
      strap_cnt_q <= strap_cnt_d;
      strap_done_q <= strap_done_d;
      dev_addr_q <= dev_addr_d;
      seen_q <= seen_d;
      cst_q <= cst_d;
      reg_addr_q <= reg_addr_d;
      reg_wdata_q <= reg_wdata_d;
      reg_wr_q <= reg_wr_d;
      rd_q <= rd_d;
    end
  end

  // ==========================================================
  // link engine: samples on the rising clock edge
  // dev_addr_q and rd_q are quasi-static: each is
  // settled many core cycles before the link edge that reads it; the event payload changes with tgl_q and the core reads it once evt_s toggles
  assign link_rst = i_sys_rst | clr_q;
  assign byte_w = {shf_q, i_sda};

  always_comb begin
    lst_d = lst_q;
    bcnt_d = (bcnt_q == SMCI_ACK_SLOT) ? 4'h0 : bcnt_q + 4'h1;
    shf_d = byte_w[6:0];
    ack_d = 1'b0;
    ara_d = ara_q;
    ptr_d = ptr_q;
    tgl_d = tgl_q;
    ewr_d = ewr_q;
    eaddr_d = eaddr_q;
    edata_d = edata_q;
    if (bcnt_q == SMCI_LAST_BIT) begin
      unique case (lst_q)
        LK_ADDR: begin
          if (byte_w[7:1] == dev_addr_q) begin
            ack_d = 1'b1;
            ara_d = 1'b0;
            lst_d = byte_w[0] ? LK_RFIRST : LK_REG;
          end else if ((byte_w[7:1] == SMCI_ARA_ADDR) && byte_w[0]) begin
            ack_d = 1'b1;
            ara_d = 1'b1;
            lst_d = LK_RFIRST;
          end else begin
            lst_d = LK_IGNORE;
          end
        end
        LK_REG: begin
          ack_d = 1'b1;
          ptr_d = byte_w;
          ewr_d = 1'b0;
          tgl_d = ~tgl_q;
          lst_d = LK_WDATA;
        end
        LK_WDATA: begin
          ack_d = 1'b1;
          eaddr_d = ptr_q;
          edata_d = byte_w;
          ewr_d = 1'b1;
          tgl_d = ~tgl_q;
          ptr_d = ptr_q + 8'h01;
        end
        default: begin
          ack_d = 1'b0;
        end
      endcase
    end else if (bcnt_q == SMCI_ACK_SLOT) begin
      if (lst_q == LK_RFIRST) begin
        lst_d = LK_RDATA;
      end else if (lst_q == LK_RDATA) begin
        if (i_sda) begin
          lst_d = LK_IGNORE;
        end else if (!ara_q) begin
          ptr_d = ptr_q + 8'h01;
          ewr_d = 1'b0;
          tgl_d = ~tgl_q;
        end
      end
    end
  end

  // protocol state; cleared by every start, stop and guard expiry
  always_ff @(posedge i_serial_clock_pin or posedge link_rst) begin
    if (link_rst) begin
      lst_q <= LK_ADDR;
      bcnt_q <= 4'h0;
      shf_q <= 7'h00;
      ack_q <= 1'b0;
      ara_q <= 1'b0;
    end else begin
      lst_q <= lst_d;
      bcnt_q <= bcnt_d;
      shf_q <= shf_d;
      ack_q <= ack_d;
      ara_q <= ara_d;
    end
  end

  // pointer and event payload survive a repeated start
  always_ff @(posedge i_serial_clock_pin or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ptr_q <= SMCI_PTR_RST;
      tgl_q <= 1'b0;
      ewr_q <= 1'b0;
      eaddr_q <= 8'h00;
      edata_q <= 8'h00;
    end else begin
      ptr_q <= ptr_d;
      tgl_q <= tgl_d;
      ewr_q <= ewr_d;
      eaddr_q <= eaddr_d;
      edata_q <= edata_d;
    end
  end

  // ==========================================================
  // link driver: changes data only while the clock is low
  always_comb begin
    tx_d = tx_q;
    oe_d = 1'b0;
    if (bcnt_q == SMCI_ACK_SLOT) begin
      oe_d = ack_q;
    end else if (lst_q == LK_RDATA) begin
      if (bcnt_q == 4'h0) begin
        tx_d = ara_q ? {dev_addr_q, 1'b0} : rd_q;
        oe_d = ~tx_d[7];
      end else begin
        oe_d = ~tx_q[3'(SMCI_LAST_BIT - bcnt_q)];
      end
    end
  end

  always_ff @(negedge i_serial_clock_pin or posedge link_rst) begin
    if (link_rst) begin
      tx_q <= 8'h00;
      oe_q <= 1'b0;
    end else begin
      tx_q <= tx_d;
      oe_q <= oe_d;
    end
  end

  // ==========================================================
  // outputs; an idle or unaddressed client never drives the line
  assign o_sda = 1'b0;
  assign o_sda_oe = oe_q & active_q;
  assign o_reg_addr = reg_addr_q;
  assign o_reg_wdata = reg_wdata_q;
  assign o_reg_wr = reg_wr_q;
  assign o_dev_addr = dev_addr_q;

endmodule

`default_nettype wire

// File: sim/smci_client_props.sv
// assertion checker for the serial client interface
`timescale 1ns/1ps
`default_nettype none
module smci_client_props #(
  parameter int unsigned TMO_CYCLES = 200
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // link and control
  input wire logic i_serial_clock_pin,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic i_timeout_en,
  // register port and status
  input wire logic [7:0] o_reg_addr,
  input wire logic o_reg_wr,
  input wire logic [6:0] o_dev_addr
);
  // ==========
  // cycles since reset, cycles of clock line low
  logic [2:0] up_q;
  logic [2:0] up_d;
  logic [15:0] low_q;
  logic [15:0] low_d;
  always_comb begin
    up_d = up_q + {2'h0, up_q != 3'h7};
    low_d = i_serial_clock_pin ? 16'h0 : low_q + {15'h0, low_q != 16'hffff};
  end
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      up_q <= 3'h0;
      low_q <= 16'h0;
    end else begin
      up_q <= up_d;
      low_q <= low_d;
    end
  end
  // ==========
  // properties
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  sequence s_wr_pulse;
    o_reg_wr ##1 !o_reg_wr;
  endsequence
  drive_low_a: assert property (o_sda_oe |-> !o_sda)
    else $error("data line driven high");
  wr_single_a: assert property (o_reg_wr |-> s_wr_pulse)
    else $error("write strobe too long");
  ptr_next_a: assert property (
    o_reg_wr |=> o_reg_addr == 8'($past(o_reg_addr) + 8'h01))
    else $error("pointer did not step");
  ack_after_wr_a: assert property (
    s_wr_pulse |-> ##[1:60] o_sda_oe)
    else $error("stored byte not acknowledged");
  ack_on_low_a: assert property (
    $rose(o_sda_oe) |-> !i_serial_clock_pin)
    else $error("drive began with clock high");
  bit_stands_a: assert property (
    i_serial_clock_pin && $past(i_serial_clock_pin) |-> $stable(o_sda_oe))
    else $error("drive changed with clock high");
  addr_held_a: assert property (up_q == 3'h7 |-> $stable(o_dev_addr))
    else $error("bus address changed");
  addr_legal_a: assert property (
    up_q == 3'h7 |-> o_dev_addr inside {[7'h48:7'h4f], [7'h28:7'h2e], 7'h18})
    else $error("bus address outside the code set");
  stuck_clk_a: assert property (
    i_timeout_en && low_q > 16'(TMO_CYCLES + 8) |-> !o_sda_oe)
    else $error("drive kept after stuck clock");
endmodule
bind smci_client smci_client_props #(.TMO_CYCLES(TMO_CYCLES)) i_props (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
  .i_serial_clock_pin(i_serial_clock_pin), .o_sda(o_sda),
  .o_sda_oe(o_sda_oe), .i_timeout_en(i_timeout_en),
  .o_reg_addr(o_reg_addr), .o_reg_wr(o_reg_wr), .o_dev_addr(o_dev_addr));
`default_nettype wire

// File: sim/smci_host_model.sv
// host controller model driving the two-wire link
`timescale 1ns/1ps
`default_nettype none
module smci_host_model #(
  parameter int HALF_NS = 1250
) (
  // link
  output logic o_scl,
  output logic o_sda_low,
  input wire logic i_sda
);
  // clock idles high and stands still between frames
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic bit_io(input logic b, output logic s);
    #(HALF_NS / 4);
    o_sda_low = ~b;
    #(HALF_NS * 3 / 4);
    o_scl = 1'b1;
    #(HALF_NS / 2);
    s = i_sda;
    #(HALF_NS / 2);
    o_scl = 1'b0;
  endtask
  task automatic start();
    o_sda_low = 1'b0;
    #(HALF_NS);
    o_scl = 1'b1;
    #(HALF_NS);
    o_sda_low = 1'b1;
    #(HALF_NS);
    o_scl = 1'b0;
  endtask
  task automatic stop();
    #(HALF_NS / 4);
    o_sda_low = 1'b1;
    #(HALF_NS);
    o_scl = 1'b1;
    #(HALF_NS);
    o_sda_low = 1'b0;
    #(HALF_NS * 2);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], nak);
    end
    bit_io(1'b1, nak);
  endtask
  task automatic rbyte(input logic nak, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(nak, s);
  endtask
endmodule
`default_nettype wire

// File: sim/tb_smci_client.sv
// self-checking bench for the serial client interface
`timescale 1ns/1ps
`default_nettype none
module tb_smci_client;
  localparam logic [6:0] DEV = 7'h29;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ten = 1'b0;
  logic [3:0] strap = 4'h9;
  logic scl, sda_low, sda_o, sda_oe, wr, nak;
  logic [7:0] radr, wdat, rdat, got;
  logic [6:0] dadr;
  logic [7:0] regs [256];
  int fails = 0;
  int samples_checked = 0;
  int nwr = 0;
  int n0;
  // open-drain wire with pull-up
  wire logic sda = !(sda_low || (sda_oe && !sda_o));
  always #20 clk = ~clk;
  assign rdat = regs[radr];
  always @(posedge clk) begin
    if (wr === 1'b1) begin
      regs[radr] <= wdat;
      nwr <= nwr + 1;
    end
  end
  smci_client #(.TMO_CYCLES(200)) i_dut (
    .i_core_clk(clk), .i_sys_rst(rst), .i_serial_clock_pin(scl),
    .i_sda(sda), .o_sda(sda_o), .o_sda_oe(sda_oe), .i_addr_strap(strap),
    .i_timeout_en(ten), .o_reg_addr(radr), .o_reg_wdata(wdat),
    .o_reg_wr(wr), .i_reg_rdata(rdat), .o_dev_addr(dadr));
  smci_host_model i_host (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda));
  // ==========
  // shared tasks
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_reset(input logic [3:0] code);
    @(posedge clk);
    rst <= 1'b1;
    strap <= code;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  task automatic wseq(input logic [7:0] r, input int n, input logic [7:0] d);
    i_host.start();
    i_host.wbyte({DEV, 1'b0}, nak);
    cmp({7'h0, nak}, 8'h00);
    i_host.wbyte(r, nak);
    cmp({7'h0, nak}, 8'h00);
    for (int i = 0; i < n; i++) begin
      i_host.wbyte(d + 8'(i), nak);
      cmp({7'h0, nak}, 8'h00);
    end
    i_host.stop();
  endtask
  task automatic rsetup(input logic [7:0] r);
    i_host.start();
    i_host.wbyte({DEV, 1'b0}, nak);
    cmp({7'h0, nak}, 8'h00);
    i_host.wbyte(r, nak);
    cmp({7'h0, nak}, 8'h00);
    // repeated start with no stop in between
    i_host.start();
    i_host.wbyte({DEV, 1'b1}, nak);
    cmp({7'h0, nak}, 8'h00);
  endtask
  task automatic rrecv();
    i_host.start();
    i_host.wbyte({DEV, 1'b1}, nak);
    cmp({7'h0, nak}, 8'h00);
    i_host.rbyte(1'b1, got);
    i_host.stop();
  endtask
  // ==========
  // scenarios
  task automatic t_strap();
    logic [6:0] e;
    for (int c = 0; c < 16; c++) begin
      e = (c < 8) ? {4'h9, 3'(c) ^ 3'h4} :
          (c < 15) ? {4'h5, 3'(c - 8)} : 7'h18;
      do_reset(4'(c));
      cmp({1'b0, dadr}, {1'b0, e});
    end
    strap <= 4'h9;
    repeat (6) @(posedge clk);
    cmp({1'b0, dadr}, 8'h18);
    do_reset(4'h9);
    $display("strap test done");
  endtask
  task automatic t_write();
    wseq(8'h10, 1, 8'ha5);
    cmp(regs[8'h10], 8'ha5);
    wseq(8'h20, 3, 8'h60);
    cmp(regs[8'h20], 8'h60);
    for (int i = 1; i < 3; i++) cmp(regs[8'h20 + i], 8'h60 + 8'(i));
    $display("write test done");
  endtask
  task automatic t_read();
    rsetup(8'h30);
    i_host.rbyte(1'b1, got);
    i_host.stop();
    cmp(got, 8'hcf);
    rsetup(8'h40);
    for (int i = 0; i < 3; i++) begin
      i_host.rbyte(i == 2, got);
      cmp(got, ~(8'h40 + 8'(i)));
    end
    i_host.stop();
    repeat (2) begin
      rrecv();
      cmp(got, 8'hbd);
    end
    $display("read test done");
  endtask
  task automatic t_send_bad();
    n0 = nwr;
    wseq(8'h50, 0, 8'h00);
    rrecv();
    cmp(got, 8'haf);
    i_host.start();
    i_host.wbyte({7'h2a, 1'b0}, nak);
    cmp({7'h0, nak}, 8'h01);
    i_host.wbyte(8'h11, nak);
    i_host.wbyte(8'h22, nak);
    i_host.stop();
    cmp(8'(nwr - n0), 8'h00);
    i_host.start();
    i_host.wbyte({7'h0c, 1'b1}, nak);
    cmp({7'h0, nak}, 8'h00);
    i_host.rbyte(1'b1, got);
    i_host.stop();
    cmp(got, {DEV, 1'b0});
    $display("send and refusal test done");
  endtask
  task automatic t_tmo();
    for (int g = 0; g < 2; g++) begin
      @(posedge clk);
      ten <= 1'(g);
      i_host.start();
      i_host.wbyte({DEV, 1'b0}, nak);
      // clock held low past the guard span
      #12000;
      i_host.wbyte(8'h70 + 8'(g), nak);
      cmp({7'h0, nak}, 8'(g));
      i_host.stop();
    end
    @(posedge clk);
    ten <= 1'b0;
    rrecv();
    cmp(got, 8'h8f);
    $display("timeout test done");
  endtask
  // ==========
  // sequence and watchdog
  initial begin
    for (int i = 0; i < 256; i++) regs[i] = ~8'(i);
    t_strap();
    t_write();
    t_read();
    t_send_bad();
    t_tmo();
    report_and_stop();
  end
  initial begin
    #3_000_000;
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
